// File: logic/mapper_pkg.sv
/*
 Constants, types and register map of the input function mapper.
 Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package mapper_pkg;

   typedef logic [6:0]  gin_t;
   typedef logic [7:0]  addr_t;
   typedef logic [31:0] word_t;

   // Selector codes of the mapped functions; only SEL_LAST_PIN is shared by all.
   localparam logic [3:0] SEL_LAST_PIN = 4'h6;
   localparam logic [3:0] SEL_ON       = 4'h7;
   localparam logic [3:0] SEL_OFF      = 4'h8;
   localparam logic [3:0] EMG_OFF      = 4'h7;
   localparam logic [3:0] EMG_ON       = 4'h8;
   localparam logic [3:0] POL_NC       = 4'h0;
   localparam logic [3:0] POL_NO       = 4'h1;
   localparam logic [3:0] POL_FAIL     = 4'h2;

   // Register byte addresses.
   localparam addr_t ADDR_SEL_A    = 8'h00;
   localparam addr_t ADDR_SEL_B    = 8'h04;
   localparam addr_t ADDR_HOME     = 8'h08;
   localparam addr_t ADDR_STATE    = 8'h0c;
   localparam addr_t ADDR_IRQ_STAT = 8'h10;
   localparam addr_t ADDR_IRQ_MASK = 8'h14;

   // Field positions.
   localparam int unsigned EMG_LSB      = 0;
   localparam int unsigned MOT_LSB      = 4;
   localparam int unsigned HOME_POL_LSB = 4;
   localparam int unsigned ST_EMG       = 6;
   localparam int unsigned ST_MOT       = 7;
   localparam int unsigned ST_HOME      = 8;
   localparam int unsigned ST_HFAIL     = 9;
   localparam int unsigned ST_GIN_LSB   = 16;
   localparam int unsigned IRQ_MOTION   = 0;
   localparam int unsigned IRQ_HFAIL    = 1;
   localparam int unsigned IRQ_EMERG    = 2;
   localparam int unsigned IRQ_HOME     = 3;

   // Reset values.
   localparam logic [15:0] SEL_A_RST = 16'h8888;
   localparam logic [15:0] SEL_B_RST = 16'h8807;
   localparam logic [7:0]  HOME_RST  = 8'h00;
   localparam logic [3:0]  MASK_RST  = 4'h0;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Motion input change detection limit.
   localparam int unsigned MOTION_LIMIT_US  = 125;
   localparam int unsigned CLK_MHZ          = 20;
   localparam int unsigned MOTION_LIMIT_CYC = MOTION_LIMIT_US * CLK_MHZ;

endpackage : mapper_pkg

// File: logic/map_if.sv
/*
 Bundle between the mapper top and its selector decoder.
 Assumes all members are on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface map_if;
   logic [6:0]  gin;
   logic [15:0] sel_a;
   logic [15:0] sel_b;
   logic [7:0]  home_cfg;
   logic [5:0]  prog;
   logic        emerg;
   logic        motion;
   logic        home_act;
   logic        home_fail;

   modport ctrl (output gin, sel_a, sel_b, home_cfg,
                 input  prog, emerg, motion, home_act, home_fail);
   modport dec  (input  gin, sel_a, sel_b, home_cfg,
                 output prog, emerg, motion, home_act, home_fail);
endinterface : map_if

`default_nettype wire

// File: logic/input_function_decoder.sv
/*
 Combinational decode of selector fields onto internal function levels.
 Assumes synchronised general inputs and registered selector fields.
*/
`timescale 1ns/1ps
`default_nettype none

module input_function_decoder
(
   map_if.dec m
);
   import mapper_pkg::*;

   // Picks a general input, or a forced level for the on code.
   function automatic logic pick(input logic [3:0] code,
                                 input logic [6:0] gin,
                                 input logic [3:0] on_code);
      logic r;
      r = 1'b0;
      if (code <= SEL_LAST_PIN)
         r = gin[code[2:0]];
      else if (code == on_code)
         r = 1'b1;
      return r;
   endfunction : pick

   logic [23:0] prog_codes;
   logic [3:0]  hsel;
   logic [3:0]  hpol;
   logic        hraw;

   assign prog_codes = {m.sel_b[15:8], m.sel_a};

   // Six program inputs share one encoding.
   for (genvar i = 0; i < 6; i++)
   begin : g_prog
      assign m.prog[i] = pick(prog_codes[i*4 +: 4], m.gin, SEL_ON);
   end

   // Emergency input uses swapped forced codes.
   assign m.emerg  = pick(m.sel_b[EMG_LSB +: 4], m.gin, EMG_ON);
   // Motion input has no forced codes, so every code above 6 reads as low.
   assign m.motion = (m.sel_b[MOT_LSB +: 4] <= SEL_LAST_PIN) &&
                     pick(m.sel_b[MOT_LSB +: 4], m.gin, SEL_ON);

   // Home switch with selectable polarity.
   assign hsel        = m.home_cfg[3:0];
   assign hpol        = m.home_cfg[HOME_POL_LSB +: 4];
   assign hraw        = m.gin[hsel[2:0]];
   assign m.home_fail = (hsel > SEL_LAST_PIN) || (hpol != POL_NC && hpol != POL_NO);
   assign m.home_act  = !m.home_fail && ((hpol == POL_NC) ? hraw : !hraw);

endmodule : input_function_decoder

`default_nettype wire

// File: logic/servo_input_function_mapper.sv
/*
 Servo drive input function mapper: routes seven general inputs onto
 program, emergency, motion and home switch functions, with an AXI4-Lite
 register slave and a masked sticky interrupt.
 Assumes general inputs are asynchronous pins and one 20 MHz clock.
*/
// Contract
// - Program input 1: codes 0-6 pin, 7 on, 8 off
// - Program inputs 2-4 use the same encoding
// - Program inputs 5-6 use the same encoding
// - Motion input follows chosen pin within 125 us
// - Home select codes 7-F mean home failure
// - Polarity 0: normally closed, low is inactive
// - Polarity 1 normally open; 2 home failure
`timescale 1ns/1ps
`default_nettype none

module servo_input_function_mapper
(
   input  wire  logic               sys_clk_i,
   input  wire  logic               rst_n_i,
   input  wire  mapper_pkg::gin_t   general_input_i,
   input  wire  mapper_pkg::addr_t  s_axi_awaddr_i,
   input  wire  logic               s_axi_awvalid_i,
   output var   logic               s_axi_awready_o,
   input  wire  mapper_pkg::word_t  s_axi_wdata_i,
   input  wire  logic [3:0]         s_axi_wstrb_i,
   input  wire  logic               s_axi_wvalid_i,
   output var   logic               s_axi_wready_o,
   output var   logic [1:0]         s_axi_bresp_o,
   output var   logic               s_axi_bvalid_o,
   input  wire  logic               s_axi_bready_i,
   input  wire  mapper_pkg::addr_t  s_axi_araddr_i,
   input  wire  logic               s_axi_arvalid_i,
   output var   logic               s_axi_arready_o,
   output var   mapper_pkg::word_t  s_axi_rdata_o,
   output var   logic [1:0]         s_axi_rresp_o,
   output var   logic               s_axi_rvalid_o,
   input  wire  logic               s_axi_rready_i,
   output var   logic [5:0]         program_input_o,
   output var   logic               emergency_o,
   output var   logic               motion_o,
   output var   logic               motion_change_o,
   output var   logic               home_switch_o,
   output var   logic               home_failure_o,
   output var   logic               irq_o
);
   import mapper_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   gin_t         gin_meta_q, gin_q;
   logic [15:0]  sel_a_q, sel_b_q;
   logic [7:0]   home_cfg_q;
   logic [3:0]   irq_mask_q, irq_stat_q, irq_ev, irq_clr, wstrb_q;
   logic [5:0]   prog_q;
   logic         emerg_q, motion_q, motion_chg_q, home_q, home_fail_q, irq_q;
   logic         awready_q, wready_q, aw_held_q, w_held_q, bvalid_q, arready_q, rvalid_q;
   addr_t        waddr_q;
   word_t        wdata_q, rdata_q, wmerge, rd_word;
   logic [1:0]   bresp_q, rresp_q;
   logic         do_write, rd_hit, wr_hit;

   map_if m ();

   ////////////////////////////////////////////////////////////////////////
   // Input synchroniser and decoder.

   // Two flops before any logic looks at the pins.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         {gin_meta_q, gin_q} <= '0;
      else
      begin
         gin_meta_q <= general_input_i;
         gin_q      <= gin_meta_q;
      end
   end

   // Decoder sees the synchronised pins and live selectors.
   assign m.gin      = gin_q;
   assign m.sel_a    = sel_a_q;
   assign m.sel_b    = sel_b_q;
   assign m.home_cfg = home_cfg_q;

   input_function_decoder u_dec
   (
      .m (m.dec)
   );

   // Registered function outputs; motion latency is three cycles.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         {prog_q, emerg_q, motion_q, motion_chg_q, home_q, home_fail_q} <= '0;
      else
      begin
         prog_q       <= m.prog;
         emerg_q      <= m.emerg;
         motion_q     <= m.motion;
         motion_chg_q <= m.motion != motion_q;
         home_q       <= m.home_act;
         home_fail_q  <= m.home_fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts.

   // Events: motion change and rising home failure, emergency, home.
   always_comb
   begin
      irq_ev             = '0;
      irq_ev[IRQ_MOTION] = m.motion != motion_q;
      irq_ev[IRQ_HFAIL]  = m.home_fail && !home_fail_q;
      irq_ev[IRQ_EMERG]  = m.emerg && !emerg_q;
      irq_ev[IRQ_HOME]   = m.home_act && !home_q;
      irq_clr            = '0;
      if (do_write && waddr_q == ADDR_IRQ_STAT && wstrb_q[0])
         irq_clr = wdata_q[3:0];
   end

   // Sticky status; a new event wins over a write-one clear.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         irq_stat_q <= '0;
      else
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
   end

   // Level interrupt while any unmasked bit stands.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_stat_q & irq_mask_q);
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel.

   // Merges enabled byte lanes of new data into an old word.
   function automatic word_t lane_merge(input word_t old_w,
                                        input word_t new_w,
                                        input logic [3:0] strb);
      word_t r;
      r = old_w;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = new_w[b*8 +: 8];
      return r;
   endfunction : lane_merge

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wr_hit   = waddr_q == ADDR_SEL_A || waddr_q == ADDR_SEL_B ||
                     waddr_q == ADDR_HOME || waddr_q == ADDR_IRQ_STAT ||
                     waddr_q == ADDR_IRQ_MASK;

   // Address and data are taken independently, then held.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         {awready_q, aw_held_q, waddr_q} <= '0;
      else if (s_axi_awvalid_i && awready_q)
      begin
         awready_q <= 1'b0;
         aw_held_q <= 1'b1;
         waddr_q   <= s_axi_awaddr_i;
      end
      else if (do_write)
         aw_held_q <= 1'b0;
      else if (!aw_held_q && !bvalid_q)
         awready_q <= 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         {wready_q, w_held_q, wdata_q, wstrb_q} <= '0;
      else if (s_axi_wvalid_i && wready_q)
      begin
         wready_q <= 1'b0;
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata_i;
         wstrb_q  <= s_axi_wstrb_i;
      end
      else if (do_write)
         w_held_q <= 1'b0;
      else if (!w_held_q && !bvalid_q)
         wready_q <= 1'b1;
   end

   // Response follows both halves; unmapped or read-only gives SLVERR.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         bvalid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   always_comb
   begin
      wmerge = '0;
      case (waddr_q)
         ADDR_SEL_A:    wmerge = lane_merge({16'h0000, sel_a_q}, wdata_q, wstrb_q);
         ADDR_SEL_B:    wmerge = lane_merge({16'h0000, sel_b_q}, wdata_q, wstrb_q);
         ADDR_HOME:     wmerge = lane_merge({24'h000000, home_cfg_q}, wdata_q, wstrb_q);
         ADDR_IRQ_MASK: wmerge = lane_merge({28'h0000000, irq_mask_q}, wdata_q, wstrb_q);
         default:       wmerge = '0;
      endcase
   end

   // Selector fields steer the decoder directly.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         sel_a_q    <= SEL_A_RST;
         sel_b_q    <= SEL_B_RST;
         home_cfg_q <= HOME_RST;
         irq_mask_q <= MASK_RST;
      end
      else if (do_write)
      begin
         case (waddr_q)
            ADDR_SEL_A:    sel_a_q    <= wmerge[15:0];
            ADDR_SEL_B:    sel_b_q    <= wmerge[15:0];
            ADDR_HOME:     home_cfg_q <= wmerge[7:0];
            ADDR_IRQ_MASK: irq_mask_q <= wmerge[3:0];
            default:       sel_a_q    <= sel_a_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.

   always_comb
   begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (s_axi_araddr_i)
         ADDR_SEL_A:    rd_word[15:0] = sel_a_q;
         ADDR_SEL_B:    rd_word[15:0] = sel_b_q;
         ADDR_HOME:     rd_word[7:0]  = home_cfg_q;
         ADDR_STATE:
         begin
            rd_word[5:0]             = prog_q;
            rd_word[ST_EMG]          = emerg_q;
            rd_word[ST_MOT]          = motion_q;
            rd_word[ST_HOME]         = home_q;
            rd_word[ST_HFAIL]        = home_fail_q;
            rd_word[ST_GIN_LSB +: 7] = gin_q;
         end
         ADDR_IRQ_STAT: rd_word[3:0]  = irq_stat_q;
         ADDR_IRQ_MASK: rd_word[3:0]  = irq_mask_q;
         default:       rd_hit        = 1'b0;
      endcase
   end

   // One read at a time; data returned the cycle after the address.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end
      else if (s_axi_arvalid_i && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready_i)
         rvalid_q <= 1'b0;
      else if (!rvalid_q)
         arready_q <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign {s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_bresp_o,
           s_axi_arready_o, s_axi_rvalid_o, s_axi_rdata_o, s_axi_rresp_o} =
          {awready_q, wready_q, bvalid_q, bresp_q, arready_q, rvalid_q, rdata_q, rresp_q};
   assign {program_input_o, emergency_o, motion_o, motion_change_o, home_switch_o,
           home_failure_o, irq_o} =
          {prog_q, emerg_q, motion_q, motion_chg_q, home_q, home_fail_q, irq_q};

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_PROG1_PIN: assert property (
      sel_a_q[3:0] == 4'h2 |=> prog_q[0] == $past(gin_q[2]))
      else $error("program input 1 does not follow input 2");
   AST_PROG1_FORCE: assert property (
      (sel_a_q[3:0] == SEL_ON) ##1 (sel_a_q[3:0] == SEL_OFF) |-> prog_q[0] ##1 !prog_q[0])
      else $error("program input 1 forced levels wrong");
   AST_PROG4_OFF: assert property (
      sel_a_q[15:12] == SEL_OFF |=> !prog_q[3])
      else $error("program input 4 not forced off");
   AST_PROG5_PIN: assert property (
      sel_b_q[11:8] == 4'h5 |=> prog_q[4] == $past(gin_q[5]))
      else $error("program input 5 does not follow input 5");
   AST_MOTION_LAT: assert property (
      sel_b_q[MOT_LSB +: 4] == 4'h3 && $stable(sel_b_q) && $changed(gin_q[3])
      |=> motion_q == $past(gin_q[3]) && motion_change_o)
      else $error("motion change not reported in time");
   AST_MOTION_NOFORCE: assert property (
      sel_b_q[MOT_LSB +: 4] > SEL_LAST_PIN |=> !motion_q)
      else $error("motion input forced by code above 6");
   AST_HOME_SEL_FAIL: assert property (
      home_cfg_q[3:0] > SEL_LAST_PIN |=> home_fail_q && !home_q)
      else $error("home select code above 6 not a failure");
   AST_HOME_NC: assert property (
      home_cfg_q == 8'h01 |=> home_q == $past(gin_q[1]) && !home_fail_q)
      else $error("normally closed home switch decoded wrong");
   AST_HOME_NO: assert property (
      home_cfg_q == 8'h11 |=> home_q == !$past(gin_q[1]))
      else $error("normally open home switch decoded wrong");
   AST_HOME_POL_FAIL: assert property (
      home_cfg_q[HOME_POL_LSB +: 4] == POL_FAIL |=> home_fail_q)
      else $error("polarity 2 not a home failure");
   AST_EMG_CODES: assert property (
      (sel_b_q[3:0] == EMG_ON |=> emerg_q) and
      (sel_b_q[3:0] == EMG_OFF |=> !emerg_q))
      else $error("emergency forced codes wrong");
   AST_IRQ_LEVEL: assert property (
      (irq_stat_q & irq_mask_q) != 4'h0 |=> irq_o)
      else $error("interrupt not raised for unmasked status");

endmodule : servo_input_function_mapper

`default_nettype wire

// File: test/switch_bank.sv
/*
 Model of the external switches and sensors wired to the seven general inputs.
 Assumes the bench sets the wanted contact levels at a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module switch_bank
(
   input  wire  logic [6:0] level_i,
   output wire  logic [6:0] general_input_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Contacts settle a few nanoseconds later, out of phase with the drive clock.
   assign #7 general_input_o = level_i;
endmodule : switch_bank

`default_nettype wire

// File: test/tb_servo_input_function_mapper.sv
/*
 Self-checking bench of the input function mapper: a table of mappings, then
 reset, interrupt, latency and bus error cases.
 Assumes the design package and the switch model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_servo_input_function_mapper;
   import mapper_pkg::*;

   typedef struct packed {
      logic [15:0] sa;
      logic [15:0] sb;
      logic [7:0]  hm;
      gin_t        gin;
      logic [5:0]  prog;
      logic        emg;
      logic        mot;
      logic        hsw;
      logic        hfl;
   } row_s;

   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   gin_t        level   = '0;
   gin_t        gin;
   addr_t       awaddr  = '0;
   addr_t       araddr  = '0;
   word_t       wdata   = '0;
   word_t       rdata;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [5:0]  prog;
   logic        emg, mot, mchg, hsw, hfl, irq;
   int          bad_count = 0;
   int          checks    = 0;
   int          n;
   word_t       val;
   row_s        rows [9];
   addr_t       ra [5] = '{ADDR_SEL_A, ADDR_SEL_B, ADDR_HOME, ADDR_IRQ_MASK, ADDR_IRQ_STAT};
   word_t       rv [5] = '{32'(SEL_A_RST), 32'(SEL_B_RST), 32'(HOME_RST), 32'(MASK_RST), 32'h0};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock of 50 ns period.
   always #25 sys_clk = ~sys_clk;

   switch_bank u_switch_bank (.level_i(level), .general_input_o(gin));

   servo_input_function_mapper u_servo_input_function_mapper (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .general_input_i(gin),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .program_input_o(prog),
      .emergency_o(emg), .motion_o(mot), .motion_change_o(mchg), .home_switch_o(hsw),
      .home_failure_o(hfl), .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // Counts a comparison and reports a mismatch at once.
   task automatic check_val(input string what, input word_t exp, input word_t got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   // Write cycle: each channel is released at the edge that takes it.
   task automatic axi_write(input addr_t a, input word_t d, output logic [1:0] r);
      @(posedge sys_clk);
      r = 2'h3;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_write

   // Read cycle: data and response are taken at the edge that sees rvalid.
   task automatic axi_read(input addr_t a, output word_t d, output logic [1:0] r);
      @(posedge sys_clk);
      r = 2'h3;
      d = 'x;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            r = rresp;
            d = rdata;
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_read

   // Register write that must be accepted.
   task automatic set_reg(input addr_t a, input word_t d);
      axi_write(a, d, resp);
      check_val("bresp", 32'(RESP_OKAY), 32'(resp));
   endtask : set_reg

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the few hundred cycles the tests take.
   initial
   begin
      #(50 * 20000);
      bad_count++;
      complete_run();
   end

   // Main sequence: mapping table, then reset, interrupt and bus error cases.
   initial
   begin
      rows[0] = '{16'h3210, 16'h5400, 8'h06, 7'h55, 6'h15, 1'b1, 1'b1, 1'b1, 1'b0};
      rows[1] = '{16'h6543, 16'h7861, 8'h13, 7'h2a, 6'h25, 1'b1, 1'b0, 1'b0, 1'b0};
      rows[2] = '{16'h8787, 16'h8727, 8'h15, 7'h00, 6'h15, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[3] = '{16'h9a88, 16'h7838, 8'h27, 7'h7f, 6'h20, 1'b1, 1'b1, 1'b0, 1'b1};
      rows[4] = '{16'h7777, 16'h88f3, 8'h0f, 7'h77, 6'h0f, 1'b0, 1'b0, 1'b0, 1'b1};
      rows[5] = '{16'h4444, 16'h4444, 8'h24, 7'h10, 6'h3f, 1'b1, 1'b1, 1'b0, 1'b1};
      rows[6] = '{16'h0123, 16'h3316, 8'h00, 7'h08, 6'h31, 1'b0, 1'b0, 1'b0, 1'b0};
      rows[7] = '{16'h5555, 16'h6555, 8'h11, 7'h20, 6'h1f, 1'b1, 1'b1, 1'b1, 1'b0};
      rows[8] = '{16'h2222, 16'h2202, 8'h01, 7'h04, 6'h3f, 1'b1, 1'b0, 1'b0, 1'b0};
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         level <= rows[i].gin;
         set_reg(ADDR_SEL_A, {16'h0, rows[i].sa});
         set_reg(ADDR_SEL_B, {16'h0, rows[i].sb});
         set_reg(ADDR_HOME, {24'h0, rows[i].hm});
         repeat (4) @(posedge sys_clk);
         check_val("program", 32'(rows[i].prog), 32'(prog));
         check_val("emergency", 32'(rows[i].emg), 32'(emg));
         check_val("motion", 32'(rows[i].mot), 32'(mot));
         check_val("home switch", 32'(rows[i].hsw), 32'(hsw));
         check_val("home failure", 32'(rows[i].hfl), 32'(hfl));
         axi_read(ADDR_STATE, val, resp);
         check_val("state", {9'h0, rows[i].gin, 6'h0, rows[i].hfl, rows[i].hsw,
                   rows[i].mot, rows[i].emg, rows[i].prog}, val);
         $display("row %0d done", i);
      end
      // A second reset in mid-run restores every default.
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check_val("outputs in reset", 32'h0, {21'h0, prog, emg, mot, hsw, hfl, irq});
      rst_n <= 1'b1;
      for (int j = 0; j < 5; j++)
      begin
         axi_read(ra[j], val, resp);
         check_val("reset value", rv[j], val);
      end
      level <= 7'h01;
      repeat (4) @(posedge sys_clk);
      check_val("default program", 32'h0, 32'(prog));
      check_val("default emergency", 32'h0, 32'(emg));
      check_val("default motion", 32'h1, 32'(mot));
      check_val("default home", 32'h1, 32'(hsw));
      $display("reset test done");
      // Motion change: latency, single-cycle pulse, masked interrupt and clear.
      set_reg(ADDR_IRQ_STAT, 32'hf);
      set_reg(ADDR_IRQ_MASK, 32'(1) << IRQ_MOTION);
      level <= 7'h00;
      n = 0;
      while (mchg !== 1'b1 && n < MOTION_LIMIT_CYC)
      begin
         @(posedge sys_clk);
         n++;
      end
      check_val("motion in time", 32'h1, 32'(n < MOTION_LIMIT_CYC));
      check_val("motion low", 32'h0, 32'(mot));
      @(posedge sys_clk);
      check_val("change pulse", 32'h0, 32'(mchg));
      repeat (2) @(posedge sys_clk);
      check_val("irq raised", 32'h1, 32'(irq));
      set_reg(ADDR_IRQ_STAT, 32'(1) << IRQ_MOTION);
      repeat (2) @(posedge sys_clk);
      check_val("irq cleared", 32'h0, 32'(irq));
      set_reg(ADDR_IRQ_MASK, 32'(1) << IRQ_HFAIL);
      level <= 7'h01;
      repeat (5) @(posedge sys_clk);
      check_val("irq masked", 32'h0, 32'(irq));
      set_reg(ADDR_HOME, 32'h20);
      repeat (3) @(posedge sys_clk);
      check_val("polarity failure", 32'h1, 32'(hfl));
      check_val("failure irq", 32'h1, 32'(irq));
      axi_read(ADDR_IRQ_STAT, val, resp);
      check_val("irq status", 32'h0000000b, val);
      set_reg(ADDR_IRQ_STAT, 32'hf);
      repeat (2) @(posedge sys_clk);
      check_val("irq all cleared", 32'h0, 32'(irq));
      $display("interrupt test done");
      // Unmapped and read-only places answer with an error.
      axi_read(8'h18, val, resp);
      check_val("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
      check_val("unmapped rdata", 32'h0, val);
      axi_write(ADDR_STATE, 32'h0, resp);
      check_val("state write", 32'(RESP_SLVERR), 32'(resp));
      axi_write(8'h1c, 32'h1, resp);
      check_val("unmapped write", 32'(RESP_SLVERR), 32'(resp));
      $display("bus error test done");
      complete_run();
   end
endmodule : tb_servo_input_function_mapper

`default_nettype wire
